// >>> shared/rmsc_defs.vh
// constants for the redriver mode and strap control block
`ifndef RMSC_DEFS_VH
`define RMSC_DEFS_VH
`define RMSC_MODE_PIN_NODET 2'h3
`define RMSC_MODE_SLAVE 2'h2
`define RMSC_MODE_MASTER 2'h1
`define RMSC_MODE_PIN_DET 2'h0
`define RMSC_LVL_HIGH 2'h3
`define RMSC_LVL_FLOAT 2'h2
`define RMSC_LVL_RES 2'h1
`define RMSC_LVL_LOW 2'h0
`define RMSC_SET_A_LSB 0
`define RMSC_SET_B_LSB 2
`define RMSC_SET_C_LSB 4
`define RMSC_SETTLE_NS 1000
`define RMSC_CLK_NS 4
`define RMSC_SETTLE_CYC ((`RMSC_SETTLE_NS + `RMSC_CLK_NS - 1) / `RMSC_CLK_NS)
`define RMSC_EE_TIMEOUT_CYC 4000
`endif

// >>> verilog/rmsc_level_decode.v
// four-level strap decoder: one-hot level flags to a two-bit code
`include "rmsc_defs.vh"
module rmsc_level_decode (
  input wire [3:0] levelFlags, // one-hot: [3] supply, [2] open, [1] resistor, [0] ground
  output reg [1:0] code // decoded code
);
  always @* begin
    if (levelFlags[3]) begin
      code = `RMSC_LVL_HIGH;
    end else if (levelFlags[2]) begin
      code = `RMSC_LVL_FLOAT;
    end else if (levelFlags[1]) begin
      code = `RMSC_LVL_RES;
    end else begin
      code = `RMSC_LVL_LOW;
    end
  end
endmodule // rmsc_level_decode

// >>> verilog/rmsc_channel_ctrl.v
// per-channel enable and low-power control
module rmsc_channel_ctrl (
  input wire clk, // clock
  input wire rst_n, // synchronous reset, active low
  input wire configApplied, // decoded configuration in place
  input wire powerDown, // channel power-down request
  input wire sidebandReset, // sideband reset asserted
  input wire lowPowerReq, // sideband low-power request
  input wire laneDisable, // per-channel disable
  output reg chanEnable, // channel active
  output reg chanLowPower // channel in low power
);
  always @(posedge clk) begin
    if (!rst_n) begin
      chanEnable <= 1'b0;
      chanLowPower <= 1'b0;
    end else begin
      chanEnable <= configApplied && !powerDown && !sidebandReset && !laneDisable;
      chanLowPower <= configApplied && !powerDown && !sidebandReset && lowPowerReq;
    end
  end
endmodule // rmsc_channel_ctrl

// >>> verilog/rmsc_strap_control.v
// mode strap decode, shared strap reuse and channel control of a four-channel redriver
// Functional notes
// - code 11/00: pin mode, detect off/on
// - 10 slave, 01 master, detect on
// - master: load status low on done, high on fail
// - power-down pin high stops all channels
// - pin mode: boost straps set equalization
// - two-wire: straps give six setting bits
// - pin mode: gain strap sets flat gain
// - master: EEPROM load only when read-enable low
// - pin mode: pin enables sideband; else data line
// - sideband reset low holds device reset
// - clock request high gives low power
// - sideband inputs honoured only when enabled
// - pin mode: swing select; else serial clock
// - four-level codes 11,10,01,00 by strap level
// - master: load configuration, signal completion
// - channels controlled independently; here only enable is per channel, low power is shared
`include "rmsc_defs.vh"
module rmsc_strap_control #(
  parameter EE_TIMEOUT = `RMSC_EE_TIMEOUT_CYC // cycles allowed for the EEPROM load
) (
  input wire clk, // clock
  input wire rst_n, // synchronous reset, active low
  input wire [3:0] modeLevels, // mode strap level flags
  input wire [3:0] highBoostStrapALevels, // high_boost_strap_a / setting_strap_a levels
  input wire [3:0] highBoostStrapBLevels, // high_boost_strap_b / setting_strap_b levels
  input wire [3:0] lowBoostStrapLevels, // low_boost_strap / setting_strap_c levels
  input wire [3:0] flatGainStrapLevels, // flat_gain_strap / read-enable levels
  input wire sidebandEnableIn, // shared sideband-enable / data pin input
  input wire outputLevelStrap, // shared swing / serial clock pin
  input wire channelPowerdown, // channel_powerdown pin
  input wire sidebandResetIn_n, // sideband_reset_in_n
  input wire clockRequestIn_n, // clock_request_in_n
  input wire sidebandRegEnable, // sideband enable written over two-wire
  input wire [3:0] laneDisable, // per-channel disable from two-wire settings
  input wire eeLoadDone, // EEPROM reader finished
  input wire eeLoadError, // EEPROM reader failed
  output reg [1:0] modeCode, // latched mode code
  output reg pinMode, // pin-strap configuration
  output reg slaveMode, // two-wire slave configuration
  output reg masterMode, // two-wire master configuration
  output reg rxDetectEnable, // receiver detection on
  output reg [1:0] highBoostA, // equalization strap code a
  output reg [1:0] highBoostB, // equalization strap code b
  output reg [1:0] lowBoost, // equalization strap code c
  output reg [5:0] settingBits, // two-wire setting bits
  output reg [1:0] flatGain, // flat gain code
  output reg swingHigh, // transmit swing select
  output reg sidebandActive, // sideband inputs honoured
  output reg serialPinsOwned, // shared pins serve the two-wire bus
  output reg eeLoadStart, // one-cycle start pulse to EEPROM reader
  output reg loadStatusOut, // load status pin output value (always 0)
  output reg loadStatusOe_n, // load status pin enable, low drives low
  output reg configApplied, // configuration in place
  output wire [3:0] chanEnable, // per-channel active
  output wire [3:0] chanLowPower // per-channel low power
);
  localparam [4:0] ST_SETTLE = 5'h01;
  localparam [4:0] ST_SAMPLE = 5'h02;
  localparam [4:0] ST_LOAD = 5'h04;
  localparam [4:0] ST_RUN = 5'h08;
  localparam [4:0] ST_FAIL = 5'h10;
  localparam integer SETTLE_INT = `RMSC_SETTLE_CYC;
  localparam integer TIMEOUT_INT = EE_TIMEOUT;
  // counters are 16 bits wide, so the cycle counts are cut to that width on purpose
  localparam [15:0] SETTLE_CYC = SETTLE_INT[15:0];
  localparam [15:0] TIMEOUT_CYC = TIMEOUT_INT[15:0];

  wire [1:0] modeDec;
  wire [1:0] aDec;
  wire [1:0] bDec;
  wire [1:0] cDec;
  wire [1:0] gDec;
  reg [4:0] state;
  reg [4:0] next_state;
  reg [15:0] count;
  reg readEnableLow;
  reg sidebandStrap;
  wire sideRst;
  wire sideLp;

  rmsc_level_decode uModeDec (.levelFlags(modeLevels), .code(modeDec));
  rmsc_level_decode uADec (.levelFlags(highBoostStrapALevels), .code(aDec));
  rmsc_level_decode uBDec (.levelFlags(highBoostStrapBLevels), .code(bDec));
  rmsc_level_decode uCDec (.levelFlags(lowBoostStrapLevels), .code(cDec));
  rmsc_level_decode uGDec (.levelFlags(flatGainStrapLevels), .code(gDec));

  always @* begin
    next_state = state;
    case (state)
      ST_SETTLE: begin
        if (count >= SETTLE_CYC - 16'h0001) next_state = ST_SAMPLE;
      end
      ST_SAMPLE: begin
        if (masterMode && readEnableLow) next_state = ST_LOAD;
        else next_state = ST_RUN;
      end
      ST_LOAD: begin
        if (eeLoadDone && !eeLoadError) next_state = ST_RUN;
        else if (eeLoadError || count >= TIMEOUT_CYC - 16'h0001) next_state = ST_FAIL;
      end
      ST_RUN: next_state = ST_RUN;
      ST_FAIL: next_state = ST_FAIL;
      default: next_state = ST_SETTLE;
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      state <= ST_SETTLE;
      count <= 16'h0000;
    end else begin
      state <= next_state;
      count <= (next_state != state) ? 16'h0000 : count + 16'h0001;
    end
  end

  // straps are caught once, on the last settle cycle as the sample state is entered, after release of reset
  always @(posedge clk) begin
    if (!rst_n) begin
      modeCode <= `RMSC_MODE_PIN_DET;
      pinMode <= 1'b1;
      slaveMode <= 1'b0;
      masterMode <= 1'b0;
      rxDetectEnable <= 1'b1;
      highBoostA <= 2'h0;
      highBoostB <= 2'h0;
      lowBoost <= 2'h0;
      settingBits <= 6'h00;
      flatGain <= 2'h0;
      swingHigh <= 1'b0;
      readEnableLow <= 1'b0;
      sidebandStrap <= 1'b0;
      serialPinsOwned <= 1'b0;
    end else if (state == ST_SETTLE && next_state == ST_SAMPLE) begin
      modeCode <= modeDec;
      pinMode <= (modeDec == `RMSC_MODE_PIN_NODET) || (modeDec == `RMSC_MODE_PIN_DET);
      slaveMode <= (modeDec == `RMSC_MODE_SLAVE);
      masterMode <= (modeDec == `RMSC_MODE_MASTER);
      rxDetectEnable <= (modeDec != `RMSC_MODE_PIN_NODET);
      serialPinsOwned <= (modeDec == `RMSC_MODE_SLAVE) || (modeDec == `RMSC_MODE_MASTER);
      if ((modeDec == `RMSC_MODE_PIN_NODET) || (modeDec == `RMSC_MODE_PIN_DET)) begin
        highBoostA <= aDec;
        highBoostB <= bDec;
        lowBoost <= cDec;
        flatGain <= gDec;
        swingHigh <= outputLevelStrap;
        sidebandStrap <= sidebandEnableIn;
        settingBits <= 6'h00;
      end else begin
        settingBits <= {cDec, bDec, aDec};
        readEnableLow <= (gDec == `RMSC_LVL_LOW) || (gDec == `RMSC_LVL_RES);
        sidebandStrap <= 1'b0;
      end
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      sidebandActive <= 1'b0;
      configApplied <= 1'b0;
      eeLoadStart <= 1'b0;
      loadStatusOut <= 1'b0;
      loadStatusOe_n <= 1'b1;
    end else begin
      sidebandActive <= pinMode ? sidebandStrap : sidebandRegEnable;
      configApplied <= (state == ST_RUN);
      eeLoadStart <= (state == ST_SAMPLE) && (next_state == ST_LOAD);
      loadStatusOut <= 1'b0;
      loadStatusOe_n <= !(masterMode && state == ST_RUN && readEnableLow);
    end
  end

  assign sideRst = sidebandActive && !sidebandResetIn_n;
  assign sideLp = sidebandActive && clockRequestIn_n;

  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1) begin : gChan
      rmsc_channel_ctrl uChan (
        .clk(clk),
        .rst_n(rst_n),
        .configApplied(configApplied),
        .powerDown(channelPowerdown),
        .sidebandReset(sideRst),
        .lowPowerReq(sideLp),
        .laneDisable(laneDisable[ch]),
        .chanEnable(chanEnable[ch]),
        .chanLowPower(chanLowPower[ch])
      );
    end
  endgenerate
endmodule // rmsc_strap_control

// >>> dv/rmsc_ee_model.sv
// stand-in for the eeprom reader that answers load start pulses
module rmsc_ee_model (
  input wire logic clk, // clock
  input wire logic start, // load start pulse
  input wire logic slow, // answer only after the load timeout
  input wire logic fail, // answer with an error
  output logic done, // load finished
  output logic err // load failed
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = -1;
  initial begin
    done = 1'b0;
    err = 1'b0;
  end
  // one-cycle answer, a few cycles or far beyond the timeout after start
  always @(posedge clk) begin
    done <= 1'b0;
    err <= 1'b0;
    if (start) cnt <= slow ? 40 : 3;
    else if (cnt > 0) cnt <= cnt - 1;
    else if (cnt == 0) begin
      done <= !fail;
      err <= fail;
      cnt <= -1;
    end
  end
endmodule // rmsc_ee_model

// >>> dv/rmsc_strap_control_chk.sv
// concurrent checks on the strap control ports
module rmsc_strap_control_chk (
  input wire logic clk, // clock
  input wire logic rst_n, // reset, active low
  input wire logic [1:0] modeCode, // mode code
  input wire logic pinMode, // pin mode
  input wire logic slaveMode, // slave mode
  input wire logic masterMode, // master mode
  input wire logic rxDetectEnable, // detect on
  input wire logic channelPowerdown, // power-down pin
  input wire logic sidebandResetIn_n, // sideband reset
  input wire logic clockRequestIn_n, // clock request
  input wire logic [3:0] laneDisable, // lane disables
  input wire logic sidebandActive, // sideband honoured
  input wire logic eeLoadStart, // load start
  input wire logic loadStatusOut, // status value
  input wire logic loadStatusOe_n, // status enable
  input wire logic configApplied, // config in place
  input wire logic [3:0] chanEnable, // channel on
  input wire logic [3:0] chanLowPower // channel low power
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_mode_decode: assert property (pinMode == (modeCode == 2'h3 || modeCode == 2'h0)
    && slaveMode == (modeCode == 2'h2) && masterMode == (modeCode == 2'h1)) else $error("mode flags wrong");
  a_rx_detect: assert property (rxDetectEnable == (modeCode != 2'h3))
    else $error("receiver detect wrong");
  a_pd_off: assert property (channelPowerdown |=> chanEnable == 4'h0 && chanLowPower == 4'h0)
    else $error("channels not powered down");
  a_status_pin: assert property (!loadStatusOe_n |-> masterMode && configApplied && !loadStatusOut)
    else $error("load status driven outside a finished load");
  a_start_pulse: assert property (eeLoadStart |-> masterMode ##1 !eeLoadStart)
    else $error("load start outside master mode");
  a_sb_reset: assert property ((sidebandActive && !sidebandResetIn_n)[*2] |=> chanEnable == 4'h0)
    else $error("sideband reset not honoured");
  a_low_power: assert property ((configApplied && sidebandActive && sidebandResetIn_n && clockRequestIn_n
    && !channelPowerdown)[*2] |=> chanLowPower == 4'hF) else $error("low power not entered");
  a_sb_ignore: assert property ((!sidebandActive)[*2] |=> chanLowPower == 4'h0)
    else $error("clock request honoured while sideband off");
  a_lane_ctrl: assert property ((configApplied && !channelPowerdown && !sidebandActive && $stable(laneDisable))[*2]
    |=> chanEnable == ~$past(laneDisable)) else $error("channel enables not independent");
endmodule // rmsc_strap_control_chk
bind rmsc_strap_control rmsc_strap_control_chk u_chk (.*);

// >>> dv/tb_top.sv
// self-checking bench for the strap control block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, sidebandEnableIn = 0, outputLevelStrap = 0, channelPowerdown = 0;
  logic sidebandResetIn_n = 1, clockRequestIn_n = 0, sidebandRegEnable = 0, eeLoadDone, eeLoadError;
  logic fail = 0, slow = 0, pinMode, slaveMode, masterMode, rxDetectEnable, swingHigh, sidebandActive;
  logic serialPinsOwned, eeLoadStart, loadStatusOut, loadStatusOe_n, configApplied, p;
  logic [3:0] modeLevels = 0, highBoostStrapALevels = 0, highBoostStrapBLevels = 0, lowBoostStrapLevels = 0;
  logic [3:0] flatGainStrapLevels = 0, laneDisable = 0, chanEnable, chanLowPower;
  logic [1:0] modeCode, highBoostA, highBoostB, lowBoost, flatGain, m;
  logic [5:0] settingBits;
  int checked = 0, miscompares = 0;
  // row: mode, strap a, b, c, gain, sideband/swing, expected detect
  logic [11:0] rows [5] = '{12'hDBA, 12'h315, 12'h9B1, 12'h641, 12'h4ED};
  rmsc_strap_control #(.EE_TIMEOUT(20)) u_dut (.*);
  rmsc_ee_model u_ee (.clk(clk), .start(eeLoadStart), .slow(slow), .fail(fail), .done(eeLoadDone), .err(eeLoadError));
  always #2 clk = ~clk;
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cfg(input logic [11:0] r);
    @(posedge clk);
    rst_n <= 1'b0;
    {channelPowerdown, sidebandResetIn_n, clockRequestIn_n, sidebandRegEnable, laneDisable} <= 8'h40;
    modeLevels <= 4'h1 << r[11:10];
    highBoostStrapALevels <= 4'h1 << r[9:8];
    highBoostStrapBLevels <= 4'h1 << r[7:6];
    lowBoostStrapLevels <= 4'h1 << r[5:4];
    flatGainStrapLevels <= 4'h1 << r[3:2];
    sidebandEnableIn <= r[1];
    outputLevelStrap <= r[1];
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (300) @(posedge clk);
  endtask
  // drive {power-down, reset_n, clock request, register enable}, lane disables; expect {enable, low power}
  task automatic poke(input logic [3:0] ctl, input logic [3:0] ln, input logic [7:0] exp);
    @(posedge clk);
    {channelPowerdown, sidebandResetIn_n, clockRequestIn_n, sidebandRegEnable} <= ctl;
    laneDisable <= ln;
    repeat (4) @(posedge clk);
    check("chanEnable_chanLowPower", {chanEnable, chanLowPower}, exp);
  endtask
  initial begin
    #100000;
    miscompares++;
    test_done();
  end
  initial begin
    for (int i = 0; i < 5; i++) begin
      cfg(rows[i]);
      m = rows[i][11:10];
      p = m == 2'h3 || m == 2'h0;
      check("modeCode", modeCode, m);
      check("rxDetectEnable", rxDetectEnable, rows[i][0]);
      check("modeFlags", {pinMode, slaveMode, masterMode}, {p, m == 2'h2, m == 2'h1});
      check("configApplied", configApplied, 8'h01);
      check("loadStatusOe_n", loadStatusOe_n, !(m == 2'h1 && !rows[i][3]));
      if (p) check("boost", {highBoostA, highBoostB, lowBoost}, rows[i][9:4]);
      else check("settingBits", settingBits, {rows[i][5:4], rows[i][7:6], rows[i][9:8]});
      if (p) check("gainSwingSb", {flatGain, swingHigh, sidebandActive}, {rows[i][3:2], rows[i][1], rows[i][1]});
      check("serialPinsOwned", serialPinsOwned, !p);
    end
    cfg(rows[0]);
    poke(4'h6, 4'h0, 8'hFF);
    poke(4'h0, 4'h0, 8'h00);
    poke(4'h4, 4'h5, 8'hA0);
    poke(4'hC, 4'h0, 8'h00);
    cfg(rows[1]);
    poke(4'h2, 4'h0, 8'hF0);
    cfg(rows[2]);
    modeLevels <= 4'h8;
    poke(4'h2, 4'h0, 8'hF0);
    poke(4'h7, 4'h0, 8'hFF);
    poke(4'h3, 4'h0, 8'h00);
    check("modeCodeHeld", modeCode, 8'h02);
    for (int k = 0; k < 2; k++) begin
      {fail, slow} <= k ? 2'b01 : 2'b10;
      cfg(rows[3]);
      check("loadFailed", {loadStatusOe_n, configApplied}, 8'h02);
    end
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    check("resetState", {pinMode, rxDetectEnable, configApplied, loadStatusOe_n, chanEnable}, 8'hD0);
    test_done();
  end
endmodule // tb_top
